// [idsx_defines.vh]
`ifndef IDSX_DEFINES_VH
`define IDSX_DEFINES_VH
// Opcode fields, bits 15:10 of the first word
`define IDSX_OP_DEC_SKZ 6'h0B
`define IDSX_OP_DEC_SKNZ 6'h13
`define IDSX_OP_INC 6'h0A
`define IDSX_OP_INC_SKZ 6'h0F
`define IDSX_OP_INC_SKNZ 6'h12
// Branch first word prefix, bits 15:8
`define IDSX_OP_BRANCH 8'hEF
// Second-word marker, bits 15:12
`define IDSX_OP_SECOND 4'hF
// Field positions
`define IDSX_DEST_BIT 9
`define IDSX_BANK_BIT 8
// Indexed literal offset limit
`define IDSX_IDX_LIMIT 8'h5F
// Register map, byte addresses
`define IDSX_ADDR_INSTR 12'h000
`define IDSX_ADDR_CTRL 12'h004
`define IDSX_ADDR_FILEIN 12'h008
`define IDSX_ADDR_RESULT 12'h00C
`define IDSX_ADDR_PC 12'h010
`define IDSX_ADDR_STATUS 12'h014
// Reset values
`define IDSX_RST_CTRL 8'h00
`define IDSX_RST_PC 21'h000000
// Status flag positions: C, DC, Z, OV, N
`define IDSX_FLAG_C 0
`define IDSX_FLAG_DC 1
`define IDSX_FLAG_Z 2
`define IDSX_FLAG_OV 3
`define IDSX_FLAG_N 4
`endif

// [idsx_phase_gen.v]
`timescale 1ns/1ns
`default_nettype none
// Four-phase sequencer: one enable pulse per phase
module idsx_phase_gen #(
  parameter PHASES = 4
) (
  input wire hclk, // Clock
  input wire hresetn, // Async reset, active low
  input wire run, // Advance phases
  output reg [PHASES-1:0] phase // One-hot phase
);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase <= {{(PHASES-1){1'b0}}, 1'b1};
    end else if (run) begin
      phase <= {phase[PHASES-2:0], phase[PHASES-1]};
    end
  end
endmodule // idsx_phase_gen
`default_nettype wire

// [idsx_exec.v]
`timescale 1ns/1ns
`default_nettype none
`include "idsx_defines.vh"
module idsx_exec (
  input wire hclk, // Clock, 10 MHz
  input wire hresetn, // Async reset, active low
  input wire hsel, // Slave select
  input wire [11:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write
  input wire [2:0] hsize, // Transfer size
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready in
  output reg hreadyout, // Ready out
  output reg hresp, // Response, always OKAY
  output reg [31:0] hrdata // Read data
);
  localparam S_IDLE = 4'b0001;
  localparam S_EXEC = 4'b0010;
  localparam S_NOP = 4'b0100;
  localparam S_BR2 = 4'b1000;
  reg [3:0] state;
  reg [15:0] instr;
  reg [15:0] instr2;
  reg [7:0] ctrl; // [0] ext set, [7:4] bank select
  reg [7:0] file_in;
  reg [7:0] result;
  reg [7:0] accum;
  reg [20:0] program_counter;
  reg [4:0] flags;
  reg [1:0] nops_left;
  reg busy;
  reg [11:0] dph_addr;
  reg dph_write;
  reg dph_valid;
  reg [7:0] work;
  reg [1:0] cycles_used;
  wire [3:0] phase;
  wire run = (state != S_IDLE);
  idsx_phase_gen #(.PHASES(4)) u_phase (
    .hclk(hclk),
    .hresetn(hresetn),
    .run(run),
    .phase(phase)
  );
  wire [5:0] opc = instr[15:10];
  wire is_dsz = (opc == `IDSX_OP_DEC_SKZ);
  wire is_dsnz = (opc == `IDSX_OP_DEC_SKNZ);
  wire is_inc = (opc == `IDSX_OP_INC);
  wire is_isz = (opc == `IDSX_OP_INC_SKZ);
  wire is_isnz = (opc == `IDSX_OP_INC_SKNZ);
  wire is_br = (instr[15:8] == `IDSX_OP_BRANCH);
  wire is_dec = is_dsz | is_dsnz;
  wire dest_file = instr[`IDSX_DEST_BIT];
  wire bank_bit = instr[`IDSX_BANK_BIT];
  wire next_two_word = (instr2[15:12] == `IDSX_OP_SECOND);
  // Effective operand address: mode and bank
  reg [11:0] eff_addr;
  reg idx_mode;
  always @* begin
    idx_mode = 1'b0;
    if (bank_bit) begin
      eff_addr = {ctrl[7:4], instr[7:0]};
    end else if (ctrl[0] && instr[7:0] <= `IDSX_IDX_LIMIT) begin
      idx_mode = 1'b1;
      eff_addr = {4'h0, instr[7:0]};
    end else begin
      eff_addr = {4'h0, instr[7:0]};
    end
  end
  // Operation class, latched in the decode phase and steady for the later phases
  reg cls_dec;
  reg cls_inc;
  reg cls_skz;
  reg cls_sknz;
  reg cls_br;
  reg cls_file;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cls_dec <= 1'b0;
      cls_inc <= 1'b0;
      cls_skz <= 1'b0;
      cls_sknz <= 1'b0;
      cls_br <= 1'b0;
      cls_file <= 1'b0;
    end else if (state == S_EXEC && phase[0]) begin
      cls_dec <= is_dec;
      cls_inc <= is_inc;
      cls_skz <= is_dsz | is_isz;
      cls_sknz <= is_dsnz | is_isnz;
      cls_br <= is_br;
      cls_file <= is_dec | is_inc | is_isz | is_isnz;
    end
  end
  wire [8:0] sum = cls_dec ? ({1'b0, work} + 9'h1FF) : ({1'b0, work} + 9'h001);
  wire zero_res = (sum[7:0] == 8'h00);
  wire skip_now = (cls_skz & zero_res)
    | (cls_sknz & ~zero_res);
  wire acc_ok = hsel && hready && htrans[1];
  wire wr_done = dph_valid && dph_write;
  wire instr_wr = wr_done && (dph_addr == `IDSX_ADDR_INSTR) && !busy;
  wire [20:0] skip_step = next_two_word ? 21'h000006 : 21'h000004;
  // Bus side: zero wait states, response always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_addr <= 12'h000;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      dph_valid <= acc_ok;
      if (acc_ok) begin
        dph_addr <= haddr;
        dph_write <= hwrite;
      end
    end
  end
  // Read data chosen in the address phase, standing through the data phase
  reg [31:0] next_hrdata;
  always @* begin
    next_hrdata = hrdata;
    if (acc_ok && !hwrite) begin
      if (haddr == `IDSX_ADDR_INSTR) begin
        next_hrdata = {instr2, instr};
      end else if (haddr == `IDSX_ADDR_CTRL) begin
        next_hrdata = {24'h0, ctrl};
      end else if (haddr == `IDSX_ADDR_FILEIN) begin
        next_hrdata = {24'h0, file_in};
      end else if (haddr == `IDSX_ADDR_RESULT) begin
        next_hrdata = {8'h0, accum, 8'h0, result};
      end else if (haddr == `IDSX_ADDR_PC) begin
        next_hrdata = {11'h0, program_counter};
      end else if (haddr == `IDSX_ADDR_STATUS) begin
        next_hrdata = {idx_mode, eff_addr, 10'h0, cycles_used, 1'b0, busy, flags};
      end else begin
        next_hrdata = 32'h00000000;
      end
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= next_hrdata;
    end
  end
  // Software-written registers; a new instruction is refused while busy
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      instr <= 16'h0000;
      instr2 <= 16'h0000;
      ctrl <= `IDSX_RST_CTRL;
      file_in <= 8'h00;
    end else if (wr_done) begin
      if (instr_wr) begin
        instr <= hwdata[15:0];
        instr2 <= hwdata[31:16];
      end else if (dph_addr == `IDSX_ADDR_CTRL) begin
        ctrl <= hwdata[7:0];
      end else if (dph_addr == `IDSX_ADDR_FILEIN) begin
        file_in <= hwdata[7:0];
      end
    end
  end
  // Sequencer: one instruction cycle is four phases
  reg [3:0] next_state;
  reg [1:0] next_nops_left;
  reg [1:0] next_cycles_used;
  reg next_busy;
  always @* begin
    next_state = state;
    next_nops_left = nops_left;
    next_cycles_used = cycles_used;
    next_busy = busy;
    case (state)
      S_IDLE: begin
        if (instr_wr) begin
          next_busy = 1'b1;
          next_cycles_used = 2'h0;
          next_state = S_EXEC;
        end
      end
      S_EXEC: begin
        if (phase[0]) begin
          next_cycles_used = 2'h1;
        end
        if (phase[3]) begin
          if (cls_br) begin
            next_state = S_BR2;
          end else if (cls_file && skip_now) begin
            next_nops_left = next_two_word ? 2'h2 : 2'h1;
            next_state = S_NOP;
          end else begin
            next_busy = 1'b0;
            next_state = S_IDLE;
          end
        end
      end
      S_NOP: begin
        // Discarded instruction: no work in any phase
        if (phase[3]) begin
          next_cycles_used = cycles_used + 2'h1;
          next_nops_left = nops_left - 2'h1;
          if (nops_left == 2'h1) begin
            next_busy = 1'b0;
            next_state = S_IDLE;
          end
        end
      end
      S_BR2: begin
        if (phase[3]) begin
          next_cycles_used = 2'h2;
          next_busy = 1'b0;
          next_state = S_IDLE;
        end
      end
      default: begin
        next_busy = 1'b0;
        next_state = S_IDLE;
      end
    endcase
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      nops_left <= 2'h0;
      cycles_used <= 2'h0;
      busy <= 1'b0;
    end else begin
      state <= next_state;
      nops_left <= next_nops_left;
      cycles_used <= next_cycles_used;
      busy <= next_busy;
    end
  end
  // Increment flags; the skip forms leave them alone
  reg [4:0] next_flags;
  always @* begin
    next_flags = flags;
    next_flags[`IDSX_FLAG_C] = sum[8];
    next_flags[`IDSX_FLAG_DC] = (work[3:0] == 4'hF);
    next_flags[`IDSX_FLAG_Z] = zero_res;
    next_flags[`IDSX_FLAG_OV] = (work == 8'h7F);
    next_flags[`IDSX_FLAG_N] = sum[7];
  end
  // Operand read in the second phase, write-back in the last
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      work <= 8'h00;
      result <= 8'h00;
      accum <= 8'h00;
      flags <= 5'h00;
    end else if (state == S_EXEC) begin
      if (phase[1]) begin
        work <= file_in;
      end
      if (phase[3] && cls_file) begin
        if (dest_file) begin
          result <= sum[7:0];
        end else begin
          accum <= sum[7:0];
        end
        if (cls_inc) begin
          flags <= next_flags;
        end
      end
    end
  end
  // Program counter: the branch loads it in two steps, the file operations step past what they used
  reg [20:0] next_program_counter;
  always @* begin
    next_program_counter = program_counter;
    if (state == S_EXEC && phase[1] && cls_br) begin
      next_program_counter[8:1] = instr[7:0];
    end else if (state == S_EXEC && phase[3]) begin
      if (cls_br) begin
        next_program_counter[20:9] = instr2[11:0];
      end else if (cls_file && !skip_now) begin
        next_program_counter = program_counter + 21'h000002;
      end
    end else if (state == S_NOP && phase[3] && nops_left == 2'h1) begin
      next_program_counter = program_counter + skip_step;
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      program_counter <= `IDSX_RST_PC;
    end else begin
      program_counter <= next_program_counter;
    end
  end
endmodule // idsx_exec
`default_nettype wire

// [idsx_exec_monitor.sv]
`timescale 1ns/1ns
`default_nettype none
module idsx_exec_monitor (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [11:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic hready, // Ready in
  input wire logic hreadyout, // Ready out
  input wire logic hresp, // Response
  input wire logic [31:0] hrdata // Read data
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence rd_any;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  sequence rd_at(logic [11:0] a);
    hsel && hready && htrans[1] && !hwrite && haddr == a;
  endsequence
  a_ready_high: assert property (hreadyout) else $error("ready dropped");
  a_resp_okay: assert property (!hresp) else $error("error response");
  a_rdata_holds: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved");
  a_unmapped_zero: assert property (rd_any ##0 haddr > 12'h014 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_pc_even: assert property (rd_at(12'h010) |=> !hrdata[0])
    else $error("odd counter");
  a_pc_width: assert property (rd_at(12'h010) |=> hrdata[31:21] == 11'h0)
    else $error("counter too wide");
  a_index_limit: assert property (rd_at(12'h014) ##1 hrdata[31] |-> hrdata[26:19] <= 8'h5F)
    else $error("indexed mode above limit");
  a_result_clean: assert property (rd_at(12'h00C) |=> hrdata[15:8] == 8'h0)
    else $error("result spill");
endmodule // idsx_exec_monitor
bind idsx_exec idsx_exec_monitor i_idsx_exec_monitor (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
`default_nettype wire

// [tb.sv]
`timescale 1ns/1ns
`default_nettype none
`include "idsx_defines.vh"
module tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, ext = 0;
  logic [11:0] haddr = 0;
  logic [1:0] htrans = 0;
  logic [31:0] hwdata = 0, q;
  logic [20:0] pc = 0;
  logic [4:0] fl = 0;
  logic [3:0] bank_select_register = 0;
  wire [31:0] hrdata;
  wire hreadyout, hresp;
  integer mismatches = 0, tests_run = 0;
  idsx_exec i_idsx_exec (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
  initial forever #50 hclk = ~hclk;
  task automatic complete_run;
    $display("tests %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      complete_run;
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    wait_rdy;
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    q = hrdata;
  endtask
  // Issue one instruction, wait for idle, then check the cycle count, the flags and the program counter
  task automatic issue(input logic [31:0] word, input logic [1:0] c);
    int n;
    xfer(1, `IDSX_ADDR_INSTR, word);
    repeat (2) @(posedge hclk);
    n = 0;
    do begin
      xfer(0, `IDSX_ADDR_STATUS, 32'h0);
      n++;
    end while (q[5] !== 1'b0 && n < 20);
    if (n >= 20) begin
      mismatches++;
      complete_run;
    end
    chk(q[8:7], c);
    chk(q[4:0], fl);
    xfer(0, `IDSX_ADDR_PC, 32'h0);
    chk(q[20:0], pc);
  endtask
  task automatic run(input logic [5:0] op, input logic d, a, input logic [7:0] f, v,
      input logic [15:0] nx);
    logic [7:0] r;
    logic sk;
    logic [1:0] c;
    r = (op == `IDSX_OP_DEC_SKZ || op == `IDSX_OP_DEC_SKNZ) ? v - 8'h01 : v + 8'h01;
    sk = (op == `IDSX_OP_INC) ? 1'b0 :
      (op == `IDSX_OP_DEC_SKZ || op == `IDSX_OP_INC_SKZ) ? r == 8'h0 : r != 8'h0;
    c = sk ? (nx[15:12] == `IDSX_OP_SECOND ? 2'h3 : 2'h2) : 2'h1;
    pc = pc + {18'h0, c, 1'b0};
    if (op == `IDSX_OP_INC) fl = {r[7], v == 8'h7F, r == 8'h0, v[3:0] == 4'hF, v == 8'hFF};
    xfer(1, `IDSX_ADDR_FILEIN, {24'h0, v});
    issue({nx, op, d, a, f}, c);
    xfer(0, `IDSX_ADDR_STATUS, 32'h0);
    chk(q[31], !a && ext && f <= 8'h5F);
    chk(q[30:19], {a ? bank_select_register : 4'h0, f});
    xfer(0, `IDSX_ADDR_RESULT, 32'h0);
    chk(d ? q[7:0] : q[23:16], r);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    xfer(0, `IDSX_ADDR_PC, 32'h0);
    chk(q, 32'h0);
    xfer(0, 12'h018, 32'h0);
    chk(q, 32'h0);
    bank_select_register = 4'h3;
    ext = 1;
    xfer(1, `IDSX_ADDR_CTRL, {24'h0, bank_select_register, 3'h0, ext});
    run(`IDSX_OP_INC, 1, 1, 8'h12, 8'hFF, 16'h0000);
    run(`IDSX_OP_INC, 0, 1, 8'h34, 8'h7F, 16'h0000);
    run(`IDSX_OP_DEC_SKZ, 1, 1, 8'h40, 8'h01, 16'hF123);
    run(`IDSX_OP_DEC_SKZ, 0, 1, 8'h41, 8'h05, 16'h0000);
    run(`IDSX_OP_DEC_SKNZ, 1, 1, 8'h42, 8'h01, 16'h0000);
    run(`IDSX_OP_DEC_SKNZ, 0, 0, 8'h5F, 8'h00, 16'h1234);
    run(`IDSX_OP_INC_SKZ, 1, 0, 8'h60, 8'hFF, 16'h1234);
    run(`IDSX_OP_INC_SKZ, 1, 1, 8'h43, 8'h10, 16'hF000);
    run(`IDSX_OP_INC_SKNZ, 1, 1, 8'h44, 8'hFF, 16'hF000);
    run(`IDSX_OP_INC_SKNZ, 0, 1, 8'h45, 8'h10, 16'hFABC);
    pc = 21'h15BDBC;
    issue({4'hF, 12'hADE, `IDSX_OP_BRANCH, 8'hDE}, 2'h2);
    complete_run;
  end
endmodule // tb
`default_nettype wire
